// ---- hdl/service_phase_derivation.sv ----
// Functional notes
// - Code 000 passes all three measured voltages unchanged.
// - Code 001 makes phase-B voltage equal A minus C.
// - With 001 the phase-B rms sees the derived A-to-C line voltage.
// - Current bit 1 gives phase-B current as minus (A plus C).
// - Code 100 gives A-B, A-C and C-B on phases A, B, C.
// - Code 010 makes phase-B voltage A minus C; currents follow the current bit.
// - Code 011 makes phase-B voltage the negated phase-A voltage.
// - Codes 001 and 100 expect phase C to lead phase A.
// - Codes 000, 010 and 011 expect normal A-B-C sequence.
`timescale 1ns/1ns
`default_nettype none

module service_phase_derivation (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sample_valid_i,
  input wire service_phase_pkg::phase_samples_t meas_i,
  input wire logic [2:0] voltage_derivation_select_i,
  input wire logic phase_b_current_derive_i,
  output logic sample_valid_o,
  output service_phase_pkg::phase_samples_t derived_o,
  output logic seq_c_leads_a_o
);

  localparam int unsigned W = service_phase_pkg::SAMPLE_W;

  // Two guard bits hold any difference or negated sum of two samples
  // exactly, so the clamp below decides on the true value.
  localparam int unsigned WX = W + 2;

  // Channel slots of the register stage, in the order of the carrier.
  localparam int unsigned NCH = 6;
  localparam int unsigned CH_VA = 0;
  localparam int unsigned CH_VB = 1;
  localparam int unsigned CH_VC = 2;
  localparam int unsigned CH_IA = 3;
  localparam int unsigned CH_IB = 4;
  localparam int unsigned CH_IC = 5;

  // Derived candidates, all formed every cycle whatever the code.
  localparam int unsigned NCAND = 5;
  localparam int unsigned C_A_MINUS_B = 0;
  localparam int unsigned C_A_MINUS_C = 1;
  localparam int unsigned C_C_MINUS_B = 2;
  localparam int unsigned C_NEG_A = 3;
  localparam int unsigned C_NEG_AC = 4;

  // Largest and smallest sample, widened to the guard width.
  localparam logic [WX-1:0] POS_LIMIT = {3'h0, {(W-1){1'b1}}};
  localparam logic [WX-1:0] NEG_LIMIT = {3'h7, {(W-1){1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // Sign extension of the measured channels.

  function automatic logic [WX-1:0] widen(input logic [W-1:0] x);
    return {{2{x[W-1]}}, x};
  endfunction

  logic [WX-1:0] va_x;
  logic [WX-1:0] vb_x;
  logic [WX-1:0] vc_x;
  logic [WX-1:0] ia_x;
  logic [WX-1:0] ic_x;

  assign va_x = widen(meas_i.va);
  assign vb_x = widen(meas_i.vb);
  assign vc_x = widen(meas_i.vc);
  assign ia_x = widen(meas_i.ia);
  assign ic_x = widen(meas_i.ic);

  ////////////////////////////////////////////////////////////////////////////
  // Candidates saturate rather than wrap, so a full-scale line voltage
  // cannot flip sign and corrupt rms or zero crossing downstream.

  logic [WX-1:0] cand_x [NCAND];
  logic [W-1:0] cand_s [NCAND];

  assign cand_x[C_A_MINUS_B] = va_x - vb_x;
  assign cand_x[C_A_MINUS_C] = va_x - vc_x;
  assign cand_x[C_C_MINUS_B] = vc_x - vb_x;
  assign cand_x[C_NEG_A] = '0 - va_x;
  assign cand_x[C_NEG_AC] = '0 - (ia_x + ic_x);

  for (genvar g = 0; g < NCAND; g++) begin : g_clamp
    logic above;
    logic below;

    assign above = $signed(cand_x[g]) > $signed(POS_LIMIT);
    assign below = $signed(cand_x[g]) < $signed(NEG_LIMIT);
    assign cand_s[g] = above ? POS_LIMIT[W-1:0] :
                       below ? NEG_LIMIT[W-1:0] : cand_x[g][W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code decode. The selects are taken as synchronous to the sample clock;
  // software must not change them while a sample is in flight.

  logic use_a_minus_c;
  logic use_neg_a;
  logic use_series;
  logic c_leads_a;

  always_comb begin
    use_a_minus_c = 1'b0;
    use_neg_a = 1'b0;
    use_series = 1'b0;
    c_leads_a = 1'b0;
    case (voltage_derivation_select_i)
      service_phase_pkg::VSEL_MEASURED: begin
        c_leads_a = 1'b0;
      end
      service_phase_pkg::VSEL_DELTA_AC: begin
        use_a_minus_c = 1'b1;
        c_leads_a = 1'b1;
      end
      service_phase_pkg::VSEL_WYE_NB: begin
        use_a_minus_c = 1'b1;
      end
      service_phase_pkg::VSEL_DELTA_NB: begin
        use_neg_a = 1'b1;
      end
      service_phase_pkg::VSEL_DELTA_SER: begin
        use_series = 1'b1;
        c_leads_a = 1'b1;
      end
      default: begin
        // Unused codes pass measured voltages, the safe choice for a
        // misprogrammed meter.
        c_leads_a = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel selection.

  logic [W-1:0] nxt [NCH];

  always_comb begin
    nxt[CH_VA] = meas_i.va;
    nxt[CH_VB] = meas_i.vb;
    nxt[CH_VC] = meas_i.vc;
    nxt[CH_IA] = meas_i.ia;
    nxt[CH_IB] = meas_i.ib;
    nxt[CH_IC] = meas_i.ic;
    if (use_series) begin
      nxt[CH_VA] = cand_s[C_A_MINUS_B];
      nxt[CH_VC] = cand_s[C_C_MINUS_B];
    end
    if (use_a_minus_c || use_series) begin
      nxt[CH_VB] = cand_s[C_A_MINUS_C];
    end else if (use_neg_a) begin
      nxt[CH_VB] = cand_s[C_NEG_A];
    end
    if (phase_b_current_derive_i) begin
      nxt[CH_IB] = cand_s[C_NEG_AC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One register stage per channel. The rms, power and zero-crossing
  // engines read only these registers, so a derived stream looks exactly
  // like a measured one downstream.

  logic [W-1:0] ch_q [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_stage
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        ch_q[c] <= service_phase_pkg::SAMPLE_RST;
      end else if (sample_valid_i) begin
        ch_q[c] <= nxt[c];
      end
    end
  end

  assign derived_o = {ch_q[CH_VA], ch_q[CH_VB], ch_q[CH_VC],
                      ch_q[CH_IA], ch_q[CH_IB], ch_q[CH_IC]};

  ////////////////////////////////////////////////////////////////////////////
  // Sample strobe and phase-sequence expectation.

  logic valid_q;
  logic c_leads_a_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= sample_valid_i;
    end
  end

  // The expectation follows the code every cycle, not the sample strobe, so it
  // changes one cycle after a code change, before the first new sample.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      c_leads_a_q <= 1'b0;
    end else begin
      c_leads_a_q <= c_leads_a;
    end
  end

  assign sample_valid_o = valid_q;
  assign seq_c_leads_a_o = c_leads_a_q;

endmodule
`default_nettype wire

// ---- hdl/service_phase_pkg.sv ----
package service_phase_pkg;

  // Sample width of every phase channel, signed two's complement.
  localparam int unsigned SAMPLE_W = 24;

  // Voltage derivation codes.
  localparam logic [2:0] VSEL_MEASURED = 3'h0;
  localparam logic [2:0] VSEL_DELTA_AC = 3'h1;
  localparam logic [2:0] VSEL_WYE_NB = 3'h2;
  localparam logic [2:0] VSEL_DELTA_NB = 3'h3;
  localparam logic [2:0] VSEL_DELTA_SER = 3'h4;

  // Reset value of the output streams.
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 24'h000000;

  typedef struct packed {
    logic [SAMPLE_W-1:0] va;
    logic [SAMPLE_W-1:0] vb;
    logic [SAMPLE_W-1:0] vc;
    logic [SAMPLE_W-1:0] ia;
    logic [SAMPLE_W-1:0] ib;
    logic [SAMPLE_W-1:0] ic;
  } phase_samples_t;

endpackage

// ---- tb/service_phase_derivation_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module spd_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sample_valid_i,
  input wire service_phase_pkg::phase_samples_t meas_i,
  input wire logic [2:0] voltage_derivation_select_i,
  input wire logic phase_b_current_derive_i,
  input wire logic sample_valid_o,
  input wire service_phase_pkg::phase_samples_t derived_o,
  input wire logic seq_c_leads_a_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Clamps an exact result to the signed sample range.
  function automatic logic [23:0] clamp(input logic signed [25:0] t);
    if (t > 26'sh7FFFFF) return 24'h7FFFFF;
    if (t < 26'sh3800000) return 24'h800000;
    return t[23:0];
  endfunction
  property p_lag; sample_valid_i |=> sample_valid_o; endproperty
  a_lag: assert property (p_lag) else $error("bad valid");
  property p_idle; !sample_valid_i |=> !sample_valid_o && $stable(derived_o); endproperty
  a_idle: assert property (p_idle) else $error("output moved without a sample");
  property p_seq;
    ##1 seq_c_leads_a_o == ($past(voltage_derivation_select_i) inside {3'h1, 3'h4});
  endproperty
  a_seq: assert property (p_seq) else $error("bad seq");
  property p_meas;
    sample_valid_i && (voltage_derivation_select_i inside {3'h0, 3'h5, 3'h6, 3'h7}) |=>
      derived_o.va == $past(meas_i.va) && derived_o.vb == $past(meas_i.vb) &&
      derived_o.vc == $past(meas_i.vc);
  endproperty
  a_meas: assert property (p_meas) else $error("measured voltage altered");
  property p_vb_ac;
    sample_valid_i && (voltage_derivation_select_i inside {3'h1, 3'h2, 3'h4}) |=>
      derived_o.vb == clamp($signed($past(meas_i.va)) - $signed($past(meas_i.vc)));
  endproperty
  a_vb_ac: assert property (p_vb_ac) else $error("bad derived vb");
  property p_vb_neg;
    sample_valid_i && voltage_derivation_select_i == 3'h3 |=>
      derived_o.vb == clamp(-$signed($past(meas_i.va)));
  endproperty
  a_vb_neg: assert property (p_vb_neg) else $error("bad negated vb");
  property p_series;
    sample_valid_i && voltage_derivation_select_i == 3'h4 |=>
      derived_o.va == clamp($signed($past(meas_i.va)) - $signed($past(meas_i.vb))) &&
      derived_o.vc == clamp($signed($past(meas_i.vc)) - $signed($past(meas_i.vb)));
  endproperty
  a_series: assert property (p_series) else $error("bad series voltages");
  property p_ib;
    sample_valid_i |=> derived_o.ib == ($past(phase_b_current_derive_i) ?
      clamp(-($signed($past(meas_i.ia)) + $signed($past(meas_i.ic)))) : $past(meas_i.ib));
  endproperty
  a_ib: assert property (p_ib) else $error("bad phase b current");
endmodule
bind service_phase_derivation spd_chk spd_chk_inst (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .sample_valid_i(sample_valid_i),
  .meas_i(meas_i),
  .voltage_derivation_select_i(voltage_derivation_select_i),
  .phase_b_current_derive_i(phase_b_current_derive_i),
  .sample_valid_o(sample_valid_o),
  .derived_o(derived_o),
  .seq_c_leads_a_o(seq_c_leads_a_o)
);
`default_nettype wire

// ---- tb/tb_service_phase_derivation.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_service_phase_derivation;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic vi = 1'h0;
  logic vo;
  logic sq;
  logic [2:0] sel = 3'h0;
  logic derive = 1'h0;
  service_phase_pkg::phase_samples_t m = {24'h5, 24'h9, 24'h3, 24'h7, 24'h1, 24'h4};
  service_phase_pkg::phase_samples_t d;
  int fails = 0;
  int checked = 0;
  service_phase_derivation service_phase_derivation_inst (
    .core_clk_i(clk),
    .rst_i(rst),
    .sample_valid_i(vi),
    .meas_i(m),
    .voltage_derivation_select_i(sel),
    .phase_b_current_derive_i(derive),
    .sample_valid_o(vo),
    .derived_o(d),
    .seq_c_leads_a_o(sq)
  );
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t value %0h wanted %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Every code with both current settings, on small positive samples.
  task automatic codes();
    logic [23:0] e_vb;
    m = {24'h5, 24'h9, 24'h3, 24'h7, 24'h1, 24'h4};
    vi = 1'h1;
    for (int c = 0; c < 16; c++) begin
      sel = 3'(c);
      derive = c[3];
      e_vb = (sel inside {3'h1, 3'h2, 3'h4}) ? 24'h2 : (sel == 3'h3) ? -24'h5 : 24'h9;
      @(negedge clk);
      chk(d.va, sel == 3'h4 ? -24'h4 : 24'h5);
      chk(d.vb, e_vb);
      chk(d.vc, sel == 3'h4 ? -24'h6 : 24'h3);
      chk(d.ia, 24'h7);
      chk(d.ib, derive ? -24'hB : 24'h1);
      chk(d.ic, 24'h4);
      chk(vo, 24'h1);
      chk(sq, (sel == 3'h1 || sel == 3'h4) ? 24'h1 : 24'h0);
    end
  endtask
  // Full-scale samples must clamp, and outputs must hold without a strobe.
  task automatic sat_hold();
    sel = 3'h1;
    derive = 1'h1;
    vi = 1'h1;
    m = {24'h7FFFFF, 24'h9, 24'h800000, 24'h800000, 24'h1, 24'h800000};
    @(negedge clk);
    chk(d.vb, 24'h7FFFFF);
    chk(d.ib, 24'h7FFFFF);
    vi = 1'h0;
    m = {24'h800000, 24'h800000, 24'h2, 24'h3, 24'h4, 24'h5};
    @(negedge clk);
    chk(vo, 24'h0);
    chk(d.vb, 24'h7FFFFF);
    sel = 3'h3;
    vi = 1'h1;
    @(negedge clk);
    chk(d.vb, 24'h7FFFFF);
    sel = 3'h4;
    m = {24'h7FFFFF, 24'h800000, 24'h2, 24'h3, 24'h4, 24'h5};
    @(negedge clk);
    chk(d.va, 24'h7FFFFF);
  endtask
  // Host totals built from the derived streams as software would.
  task automatic host_totals();
    logic [23:0] total;
    m = {24'h5, 24'h9, 24'h3, 24'h7, 24'h1, 24'h4};
    sel = 3'h1;
    derive = 1'h1;
    vi = 1'h1;
    @(negedge clk);
    total = d.va * d.ia + d.vc * d.ic;
    chk(total, 24'h2F);
    sel = 3'h0;
    derive = 1'h0;
    @(negedge clk);
    total = d.va * d.ia + d.vb * d.ib + d.vc * d.ic;
    chk(total, 24'h38);
  endtask
  // Reset in mid-run clears phase-B voltage, the valid strobe and the sequence flag.
  task automatic reset_mid();
    rst = 1'h1;
    @(negedge clk);
    chk(d.vb, 24'h0);
    chk(vo, 24'h0);
    chk(sq, 24'h0);
    repeat (2) @(negedge clk);
    rst = 1'h0;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'h0;
    codes();
    sat_hold();
    host_totals();
    reset_mid();
    codes();
    complete_run();
  end
  initial begin
    #1000;
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
